// ---- rtl/sgil_object.sv ----
// Summary of operation
// - Open and close directions each have their own interlock enable set and are judged separately.
// - Each blocking condition comes from another object status, a software output or a digital input.
// - Events and log entries are made on every monitored change and on command execution or failure.
// - Per event enables choose whether on edges, off edges or both reach the event buffer.
// - The operation log is a circular store keeping the latest 12 entries, the oldest overwritten.
// - Every event carries its timestamp and a snapshot of the process data.
// - The object raises the full set of position, cart, request, command, blocked, ready, sync, fail, trip events.
// - Contact abrasion alarm gives an on event when it rises and an off event when it falls.
// - Operating time exceeded and both local mode indications give on and off events.
// - Each log entry records opening time from open command acceptance to open status.
// - Each log entry records closing time from close command acceptance to closed status.
// - Each log entry holds stamp, event, object and cart status, fail causes, command sources and general status.
// - After the traverse time both status inputs give bad and neither gives intermediate.
// - No status change within the termination timeout ends the command with a fail event.
`timescale 1ns/1ns
`default_nettype none
`include "sgil_consts.svh"
module sgil_object #(
  parameter int TRAVERSE_CYC = `SGIL_TRAVERSE_MS * `SGIL_MS_CYCLES,
  parameter int TIMEOUT_CYC  = `SGIL_TIMEOUT_MS * `SGIL_MS_CYCLES,
  parameter int MS_CYC       = `SGIL_MS_CYCLES
) (
  // Clock and reset
  input  wire logic                 sys_clk,
  input  wire logic                 rst,
  // Field inputs, asynchronous
  input  wire sgil_pkg::sgil_status_t status_pin,
  input  wire sgil_pkg::sgil_blk_src_t open_blk_src,
  input  wire sgil_pkg::sgil_blk_src_t close_blk_src,
  // Interlock enables per direction
  input  wire sgil_pkg::sgil_blk_src_t open_blk_en,
  input  wire sgil_pkg::sgil_blk_src_t close_blk_en,
  // Commands, same clock
  input  wire logic                 open_req,
  input  wire logic                 close_req,
  input  wire logic [1:0]           cmd_src,
  // Event selection
  input  wire logic [`SGIL_EV_NUM-1:0] ev_on_en,
  input  wire logic [`SGIL_EV_NUM-1:0] ev_off_en,
  // Outputs, and the log read index input
  output logic                      open_cmd,
  output logic                      close_cmd,
  output logic                      event_valid,
  output sgil_pkg::sgil_event_t     event_out,
  input  wire logic [3:0]           log_rd_idx,
  output sgil_pkg::sgil_entry_t     log_rd_data,
  output logic [3:0]                log_count
);
  localparam int NS = $bits(sgil_pkg::sgil_status_t);
  // Three stage sync, change accepted when stages two and three agree
  logic [NS-1:0] s1_reg, s2_reg, s3_reg, st_reg;
  logic [NS-1:0] st_next;
  logic [8:0] b1_reg, b2_reg, b3_reg, bo_reg, bc_reg, bo_next, bc_next;
  logic [8:0] c1_reg, c2_reg, c3_reg;
  always_comb
  begin
    st_next = st_reg;
    bo_next = bo_reg;
    bc_next = bc_reg;
    for (int i = 0; i < NS; i++)
      if (s2_reg[i] == s3_reg[i]) st_next[i] = s3_reg[i];
    for (int i = 0; i < 9; i++)
    begin
      if (b2_reg[i] == b3_reg[i]) bo_next[i] = b3_reg[i];
      if (c2_reg[i] == c3_reg[i]) bc_next[i] = c3_reg[i];
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      s1_reg <= '0; s2_reg <= '0; s3_reg <= '0; st_reg <= '0;
      b1_reg <= '0; b2_reg <= '0; b3_reg <= '0; bo_reg <= '0;
      c1_reg <= '0; c2_reg <= '0; c3_reg <= '0; bc_reg <= '0;
    end
    else
    begin
      s1_reg <= status_pin; s2_reg <= s1_reg; s3_reg <= s2_reg; st_reg <= st_next;
      b1_reg <= open_blk_src; b2_reg <= b1_reg; b3_reg <= b2_reg; bo_reg <= bo_next;
      c1_reg <= close_blk_src; c2_reg <= c1_reg; c3_reg <= c2_reg; bc_reg <= bc_next;
    end
  end
  sgil_pkg::sgil_status_t st;
  assign st = st_reg;
  // Blocks are sampled only; the 5 ms lead is the sender's job
  logic open_blocked, close_blocked;
  assign open_blocked  = |(bo_reg & open_blk_en);
  assign close_blocked = |(bc_reg & close_blk_en);

  // Position decode with traverse delay
  function automatic sgil_pkg::sgil_pos_t pos_dec(input logic a, input logic b);
    unique case ({a, b})
      2'b00: pos_dec = sgil_pkg::SGIL_ST_INTER;
      2'b10: pos_dec = sgil_pkg::SGIL_ST_OPEN;
      2'b01: pos_dec = sgil_pkg::SGIL_ST_CLOSED;
      2'b11: pos_dec = sgil_pkg::SGIL_ST_BAD;
    endcase
  endfunction : pos_dec

  typedef enum logic [1:0] {SGIL_IDLE, SGIL_OPENING, SGIL_CLOSING} sgil_ctl_t;
  sgil_ctl_t ctl_reg, ctl_next;
  sgil_pkg::sgil_pos_t pos_reg, pos_next, cart_reg, cart_next;
  logic [31:0] trav_reg, trav_next, tmo_reg, tmo_next, ms_reg, ms_next, stamp_reg, stamp_next;
  logic [31:0] run_ms_reg, run_ms_next;
  logic [15:0] otime_reg, otime_next, ctime_reg, ctime_next;
  sgil_pkg::sgil_fail_t ofail_reg, ofail_next, cfail_reg, cfail_next;
  logic [1:0] osrc_reg, osrc_next, csrc_reg, csrc_next;
  sgil_pkg::sgil_pos_t raw_pos;
  assign raw_pos = pos_dec(st.open_st, st.close_st);
  logic [`SGIL_EV_NUM-1:0] ev_hit;
  logic open_acc, close_acc;
  always_comb
  begin
    ctl_next = ctl_reg;
    trav_next = trav_reg;
    tmo_next = tmo_reg;
    pos_next = pos_reg;
    ms_next = ms_reg + 32'h1;
    stamp_next = stamp_reg;
    run_ms_next = run_ms_reg;
    otime_next = otime_reg; ctime_next = ctime_reg;
    ofail_next = ofail_reg; cfail_next = cfail_reg;
    osrc_next = osrc_reg; csrc_next = csrc_reg;
    cart_next = pos_dec(st.cart_out, st.cart_in);
    ev_hit = '0;
    open_acc = 1'b0;
    close_acc = 1'b0;
    if (ms_reg == 32'(MS_CYC - 1))
    begin
      ms_next = '0;
      stamp_next = stamp_reg + 32'h1;
      if (ctl_reg != SGIL_IDLE) run_ms_next = run_ms_reg + 32'h1;
    end
    // Clean states show at once, mixed ones only after traverse time
    if (raw_pos == sgil_pkg::SGIL_ST_OPEN || raw_pos == sgil_pkg::SGIL_ST_CLOSED)
    begin
      pos_next = raw_pos;
      trav_next = '0;
    end
    else if (trav_reg >= 32'(TRAVERSE_CYC - 1))
      pos_next = raw_pos;
    else
      trav_next = trav_reg + 32'h1;
    unique case (ctl_reg)
      SGIL_IDLE:
      begin
        tmo_next = '0;
        run_ms_next = '0;
        if (open_req)
        begin
          if (open_blocked)
          begin
            ofail_next = sgil_pkg::SGIL_FAIL_BLOCKED;
            ev_hit[16] = 1'b1;
          end
          else
          begin
            open_acc = 1'b1;
            osrc_next = cmd_src;
            ctl_next = SGIL_OPENING;
          end
        end
        else if (close_req)
        begin
          if (close_blocked)
          begin
            cfail_next = sgil_pkg::SGIL_FAIL_BLOCKED;
            ev_hit[18] = 1'b1;
          end
          else
          begin
            close_acc = 1'b1;
            csrc_next = cmd_src;
            ctl_next = SGIL_CLOSING;
          end
        end
      end
      SGIL_OPENING, SGIL_CLOSING:
      begin
        tmo_next = tmo_reg + 32'h1;
        if (ctl_reg == SGIL_OPENING && st.open_st && !st.close_st)
        begin
          otime_next = run_ms_reg[15:0];
          ofail_next = sgil_pkg::SGIL_FAIL_NONE;
          ctl_next = SGIL_IDLE;
        end
        else if (ctl_reg == SGIL_CLOSING && st.close_st && !st.open_st)
        begin
          ctime_next = run_ms_reg[15:0];
          cfail_next = sgil_pkg::SGIL_FAIL_NONE;
          ctl_next = SGIL_IDLE;
        end
        else if (tmo_reg >= 32'(TIMEOUT_CYC - 1))
        begin
          ctl_next = SGIL_IDLE;
          if (ctl_reg == SGIL_OPENING)
          begin
            ofail_next = sgil_pkg::SGIL_FAIL_TIMEOUT;
            ev_hit[24] = 1'b1;
          end
          else
          begin
            cfail_next = sgil_pkg::SGIL_FAIL_TIMEOUT;
            ev_hit[25] = 1'b1;
          end
        end
      end
    endcase
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctl_reg <= SGIL_IDLE; pos_reg <= sgil_pkg::SGIL_ST_INTER; cart_reg <= sgil_pkg::SGIL_ST_INTER;
      trav_reg <= '0; tmo_reg <= '0; ms_reg <= '0; stamp_reg <= '0; run_ms_reg <= '0;
      otime_reg <= '0; ctime_reg <= '0;
      ofail_reg <= sgil_pkg::SGIL_FAIL_NONE; cfail_reg <= sgil_pkg::SGIL_FAIL_NONE;
      osrc_reg <= '0; csrc_reg <= '0;
    end
    else
    begin
      ctl_reg <= ctl_next; pos_reg <= pos_next; cart_reg <= cart_next;
      trav_reg <= trav_next; tmo_reg <= tmo_next; ms_reg <= ms_next; stamp_reg <= stamp_next;
      run_ms_reg <= run_ms_next; otime_reg <= otime_next; ctime_reg <= ctime_next;
      ofail_reg <= ofail_next; cfail_reg <= cfail_next; osrc_reg <= osrc_next; csrc_reg <= csrc_next;
    end
  end
  assign open_cmd  = (ctl_reg == SGIL_OPENING);
  assign close_cmd = (ctl_reg == SGIL_CLOSING);

  // Level view of each event line; pairs share one bit, odd index is the off side
  logic [`SGIL_EV_NUM-1:0] lvl_now, lvl_reg;
  always_comb
  begin
    lvl_now = '0;
    lvl_now[0]  = pos_reg == sgil_pkg::SGIL_ST_INTER;
    lvl_now[1]  = pos_reg == sgil_pkg::SGIL_ST_OPEN;
    lvl_now[2]  = pos_reg == sgil_pkg::SGIL_ST_CLOSED;
    lvl_now[3]  = pos_reg == sgil_pkg::SGIL_ST_BAD;
    lvl_now[4]  = cart_reg == sgil_pkg::SGIL_ST_INTER;
    lvl_now[5]  = cart_reg == sgil_pkg::SGIL_ST_OPEN;
    lvl_now[6]  = cart_reg == sgil_pkg::SGIL_ST_CLOSED;
    lvl_now[7]  = cart_reg == sgil_pkg::SGIL_ST_BAD;
    lvl_now[8]  = open_req;
    lvl_now[10] = open_cmd;
    lvl_now[12] = close_req;
    lvl_now[14] = close_cmd;
    lvl_now[16] = open_req & open_blocked;
    lvl_now[18] = close_req & close_blocked;
    lvl_now[20] = st.ready;
    lvl_now[22] = st.sync_ok;
    lvl_now[26] = st.final_trip;
    lvl_now[28] = st.abrasion;
    lvl_now[30] = st.op_time_exc;
    lvl_now[32] = st.cb_local;
    lvl_now[34] = st.sw_local;
  end
  // Lowest pending event goes out first, one a cycle; the others wait their turn
  logic [`SGIL_EV_NUM-1:0] fire;
  logic [`SGIL_EV_NUM-1:0] pend_reg, pend_next, pend_all;
  logic ev_any;
  logic [5:0] ev_id;
  logic ev_on;
  always_comb
  begin
    fire = '0;
    ev_any = 1'b0;
    ev_id = '0;
    ev_on = 1'b0;
    for (int i = 0; i < 8; i++)
      fire[i] = lvl_now[i] & ~lvl_reg[i] & ev_on_en[i];
    for (int i = 8; i < `SGIL_EV_NUM; i += 2)
    begin
      fire[i]   = lvl_now[i] & ~lvl_reg[i] & ev_on_en[i];
      fire[i+1] = ~lvl_now[i] & lvl_reg[i] & ev_off_en[i+1];
    end
    fire[24] = ev_hit[24] & ev_on_en[24];
    fire[25] = ev_hit[25] & ev_on_en[25];
    // Held edges survive the one-per-cycle limit; a repeat before report merges
    pend_all = pend_reg | fire;
    for (int i = `SGIL_EV_NUM - 1; i >= 0; i--)
      if (pend_all[i])
      begin
        ev_any = 1'b1;
        ev_id = 6'(i);
        ev_on = (i < 8) || (i == 25) || (i % 2 == 0);
      end
    pend_next = pend_all;
    if (ev_any) pend_next[ev_id] = 1'b0;
  end
  // Log of the latest entries, wrap overwrites the oldest
  sgil_pkg::sgil_entry_t log_mem [`SGIL_LOG_DEPTH];
  logic [3:0] wr_ptr_reg, wr_ptr_next, cnt_next;
  sgil_pkg::sgil_event_t ev_next;
  sgil_pkg::sgil_entry_t ent;
  logic log_wr;
  always_comb
  begin
    ev_next = '{stamp_ms: stamp_reg, event_id: ev_id, on_edge: ev_on, process: st};
    ent = '{stamp_ms: stamp_reg, event_id: ev_id, open_time_ms: otime_next, close_time_ms: ctime_next,
            obj_status: pos_reg, cart_status: cart_reg, open_fail: ofail_next, close_fail: cfail_next,
            open_src: osrc_next, close_src: csrc_next, general: ctl_reg};
    log_wr = ev_any | open_acc | close_acc;
    wr_ptr_next = wr_ptr_reg;
    cnt_next = log_count;
    if (log_wr)
    begin
      wr_ptr_next = (wr_ptr_reg == 4'(`SGIL_LOG_DEPTH - 1)) ? 4'h0 : wr_ptr_reg + 4'h1;
      if (log_count != 4'(`SGIL_LOG_DEPTH)) cnt_next = log_count + 4'h1;
    end
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      lvl_reg <= '0; event_valid <= 1'b0; event_out <= '0; wr_ptr_reg <= '0; log_count <= '0;
      pend_reg <= '0;
    end
    else
    begin
      lvl_reg <= lvl_now; event_valid <= ev_any; event_out <= ev_next;
      pend_reg <= pend_next;
      wr_ptr_reg <= wr_ptr_next; log_count <= cnt_next;
      if (log_wr) log_mem[wr_ptr_reg] <= ent;
    end
  end
  // Index 0 is the newest entry
  logic [4:0] rd_pos;
  always_comb
  begin
    rd_pos = {1'b0, wr_ptr_reg} + 5'(`SGIL_LOG_DEPTH) - 5'h1 - {1'b0, log_rd_idx};
    if (rd_pos >= 5'(`SGIL_LOG_DEPTH)) rd_pos = rd_pos - 5'(`SGIL_LOG_DEPTH);
  end
  always_ff @(posedge sys_clk)
  begin
    if (rst) log_rd_data <= '0;
    else log_rd_data <= (log_rd_idx < log_count) ? log_mem[rd_pos[3:0]] : '0;
  end

  a_block_refuse: assert property (@(posedge sys_clk) disable iff (rst)
    (ctl_reg == SGIL_IDLE && open_req && open_blocked) |=> !open_cmd) else $error("blocked open driven");
  a_close_refuse: assert property (@(posedge sys_clk) disable iff (rst)
    (ctl_reg == SGIL_IDLE && !open_req && close_req && close_blocked) |=> !close_cmd) else $error("blocked close");
  a_open_accept: assert property (@(posedge sys_clk) disable iff (rst)
    (ctl_reg == SGIL_IDLE && open_req && !open_blocked) |=> open_cmd) else $error("open not taken");
  a_log_bound: assert property (@(posedge sys_clk) disable iff (rst)
    log_count <= 4'(`SGIL_LOG_DEPTH) && wr_ptr_reg < 4'(`SGIL_LOG_DEPTH)) else $error("log overrun");
  a_log_count: assert property (@(posedge sys_clk) disable iff (rst)
    (log_wr && log_count < 4'(`SGIL_LOG_DEPTH)) |=> log_count == $past(log_count) + 4'h1) else $error("count");
  a_event_stamp: assert property (@(posedge sys_clk) disable iff (rst)
    ev_any |=> event_valid && event_out.stamp_ms == $past(stamp_reg)) else $error("bad stamp");
  a_event_off: assert property (@(posedge sys_clk) disable iff (rst)
    (lvl_reg[28] && !lvl_now[28] && !ev_off_en[29] && !pend_reg[29]) |=>
    !(event_valid && event_out.event_id == 6'd29)) else $error("off not filtered");
  a_abrasion_on: assert property (@(posedge sys_clk) disable iff (rst)
    (!lvl_reg[28] && lvl_now[28] && ev_on_en[28]) |-> ev_any) else $error("abrasion lost");
  a_bad_status: assert property (@(posedge sys_clk) disable iff (rst)
    (pos_reg != sgil_pkg::SGIL_ST_BAD && trav_reg < 32'(TRAVERSE_CYC - 1)) |=>
    pos_reg != sgil_pkg::SGIL_ST_BAD) else $error("bad early");
  a_cmd_exclusive: assert property (@(posedge sys_clk) disable iff (rst)
    open_cmd |-> tmo_reg < 32'(TIMEOUT_CYC) && !close_cmd) else $error("command overrun");
  c_open_ok: cover property (@(posedge sys_clk) disable iff (rst) open_cmd ##1 !open_cmd && ofail_reg == sgil_pkg::SGIL_FAIL_NONE);
  c_close_fail: cover property (@(posedge sys_clk) disable iff (rst) ev_hit[25]);
  c_blocked: cover property (@(posedge sys_clk) disable iff (rst) ev_hit[16]);
  c_log_full: cover property (@(posedge sys_clk) disable iff (rst) log_wr && log_count == 4'(`SGIL_LOG_DEPTH));
endmodule : sgil_object
`default_nettype wire

// ---- rtl/sgil_consts.svh ----
`ifndef SGIL_CONSTS_SVH
`define SGIL_CONSTS_SVH
`define SGIL_CLK_HZ         20000000
`define SGIL_MS_CYCLES      (`SGIL_CLK_HZ / 1000)
`define SGIL_BLOCK_LEAD_MS  5
`define SGIL_TRAVERSE_MS    200
`define SGIL_TIMEOUT_MS     10000
`define SGIL_LOG_DEPTH      12
`define SGIL_EV_NUM         36
`define SGIL_EV_W           6
`define SGIL_SEL_ON         0
`define SGIL_SEL_OFF        1
`endif

// ---- rtl/sgil_pkg.sv ----
package sgil_pkg;
  typedef enum logic [1:0] {SGIL_ST_INTER, SGIL_ST_OPEN, SGIL_ST_CLOSED, SGIL_ST_BAD} sgil_pos_t;
  typedef enum logic [1:0] {SGIL_FAIL_NONE, SGIL_FAIL_BLOCKED, SGIL_FAIL_TIMEOUT} sgil_fail_t;
  typedef struct packed {
    logic open_st;
    logic close_st;
    logic cart_in;
    logic cart_out;
    logic ready;
    logic sync_ok;
    logic abrasion;
    logic op_time_exc;
    logic cb_local;
    logic sw_local;
    logic final_trip;
  } sgil_status_t;
  typedef struct packed {
    logic [2:0] obj_blk;
    logic [2:0] sw_blk;
    logic [2:0] di_blk;
  } sgil_blk_src_t;
  typedef struct packed {
    logic [31:0] stamp_ms;
    logic [5:0]  event_id;
    logic [15:0] open_time_ms;
    logic [15:0] close_time_ms;
    sgil_pos_t   obj_status;
    sgil_pos_t   cart_status;
    sgil_fail_t  open_fail;
    sgil_fail_t  close_fail;
    logic [1:0]  open_src;
    logic [1:0]  close_src;
    logic [1:0]  general;
  } sgil_entry_t;
  typedef struct packed {
    logic [31:0]  stamp_ms;
    logic [5:0]   event_id;
    logic         on_edge;
    sgil_status_t process;
  } sgil_event_t;
endpackage : sgil_pkg

// ---- verification/sgil_breaker_model.sv ----
`timescale 1ns/1ns
`default_nettype none
module sgil_breaker_model (
  // Clock and reset
  input  wire logic       sys_clk,
  input  wire logic       rst,
  // Relay commands and behaviour controls
  input  wire logic       open_cmd,
  input  wire logic       close_cmd,
  input  wire logic [7:0] travel,
  input  wire logic       stuck,
  input  wire logic       welded,
  // Auxiliary contacts
  output logic            open_st,
  output logic            close_st
);
  logic [7:0] cnt_reg;
  logic       pos_open_reg;
  // Both contacts drop during travel, as on a real mechanism
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cnt_reg      <= 8'h00;
      pos_open_reg <= 1'b1;
    end
    else if (cnt_reg != 8'h00)
      cnt_reg <= cnt_reg - 8'h01;
    else if (!stuck && (open_cmd ? !pos_open_reg : (close_cmd && pos_open_reg)))
    begin
      cnt_reg      <= travel;
      pos_open_reg <= open_cmd;
    end
  end
  // Welded contacts show both positions at once
  assign open_st  = welded || (cnt_reg == 8'h00 && pos_open_reg);
  assign close_st = welded || (cnt_reg == 8'h00 && !pos_open_reg);
endmodule : sgil_breaker_model
`default_nettype wire

// ---- verification/sgil_object_bench.sv ----
`timescale 1ns/1ns
`default_nettype none
module sgil_object_bench;
  localparam int TRAV = 20;
  localparam int TOUT = 200;
  localparam int MSC  = 4;
  logic                    sys_clk, rst, open_req, close_req, stuck, welded;
  logic                    open_cmd, close_cmd, event_valid, open_st, close_st;
  logic [1:0]              cmd_src;
  logic [3:0]              log_rd_idx, log_count;
  logic [7:0]              travel;
  logic [8:0]              aux;
  logic [31:0]             rnd, last_stamp;
  logic [35:0]             ev_on_en, ev_off_en, seen;
  sgil_pkg::sgil_blk_src_t open_blk_src, close_blk_src, open_blk_en, close_blk_en;
  sgil_pkg::sgil_status_t  status_pin, last_proc;
  sgil_pkg::sgil_event_t   event_out;
  sgil_pkg::sgil_entry_t   log_rd_data;
  int                      error_cnt, samples_checked, n;
  bit                      t_ok, f_ok;
  logic [8:0]              pat [18] = '{9'h100, 9'h180, 9'h080, 9'h000, 9'h040, 9'h000, 9'h020, 9'h000, 9'h010,
                                        9'h000, 9'h008, 9'h000, 9'h004, 9'h000, 9'h002, 9'h000, 9'h001, 9'h000};
  int                      eid [18] = '{6, 7, 5, 4, 20, 21, 22, 23, 28, 29, 30, 31, 32, 33, 34, 35, 26, 27};

  assign status_pin = sgil_pkg::sgil_status_t'({open_st, close_st, aux});

  sgil_object #(.TRAVERSE_CYC(TRAV), .TIMEOUT_CYC(TOUT), .MS_CYC(MSC)) i_sgil_object (
    .sys_clk(sys_clk), .rst(rst), .status_pin(status_pin), .open_blk_src(open_blk_src),
    .close_blk_src(close_blk_src), .open_blk_en(open_blk_en), .close_blk_en(close_blk_en),
    .open_req(open_req), .close_req(close_req), .cmd_src(cmd_src), .ev_on_en(ev_on_en),
    .ev_off_en(ev_off_en), .open_cmd(open_cmd), .close_cmd(close_cmd), .event_valid(event_valid),
    .event_out(event_out), .log_rd_idx(log_rd_idx), .log_rd_data(log_rd_data), .log_count(log_count));

  sgil_breaker_model i_sgil_breaker_model (
    .sys_clk(sys_clk), .rst(rst), .open_cmd(open_cmd), .close_cmd(close_cmd), .travel(travel),
    .stuck(stuck), .welded(welded), .open_st(open_st), .close_st(close_st));

  initial
  begin
    sys_clk = 1'b0;
    forever #25 sys_clk = ~sys_clk;
  end

  // Event monitor on the falling edge, clear of the launching edge; bench clears seen per step
  always @(negedge sys_clk)
    if (event_valid === 1'b1)
    begin
      seen[event_out.event_id] <= 1'b1;
      last_proc                <= event_out.process;
      check_bit("stamp order", 1'b1, event_out.stamp_ms >= last_stamp);
      last_stamp               <= event_out.stamp_ms;
    end

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  task automatic check_bit(input string nm, input logic e, input logic g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("FAIL %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check_bit

  task automatic check_val(input string nm, input logic [31:0] e, input logic [31:0] g);
    samples_checked++;
    if (g !== e)
    begin
      error_cnt++;
      $display("FAIL %s expected %0h seen %0h", nm, e, g);
    end
  endtask : check_val

  task automatic wrap_up;
    $display("checks %0d mismatches %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : wrap_up

  task automatic tick;
    @(posedge sys_clk);
    #2;
  endtask : tick

  task automatic req(input bit op);
    open_req  = op;
    close_req = !op;
    tick;
    open_req  = 1'b0;
    close_req = 1'b0;
  endtask : req

  // Bounded wait for a command level; running out ends the run
  task automatic wait_lvl(input bit op, input logic want, input int bound, output int cnt);
    cnt = 0;
    while ((op ? open_cmd : close_cmd) !== want && cnt < bound)
    begin
      tick;
      cnt++;
    end
    if (cnt >= bound)
    begin
      error_cnt++;
      $display("FAIL command wait expected %0h seen timeout", want);
      wrap_up;
    end
  endtask : wait_lvl

  task automatic scan_log(input bit op, input int ms, input logic [1:0] src, input sgil_pkg::sgil_fail_t fl);
    sgil_pkg::sgil_entry_t e;
    int                    t;
    t_ok = 0;
    f_ok = 0;
    for (int i = 0; i < 12; i++)
    begin
      log_rd_idx = 4'(i);
      tick;
      e = log_rd_data;
      t = op ? e.open_time_ms : e.close_time_ms;
      if (t >= ms - 1 && t <= ms + 1 && (op ? e.open_src : e.close_src) === src)
        t_ok = 1;
      if ((op ? e.open_fail : e.close_fail) === fl)
        f_ok = 1;
    end
  endtask : scan_log

  task automatic operate(input bit op, input bit slow);
    travel  = slow ? 8'h28 : 8'h08 + {4'h0, rnd[3:0] % 4'hc};
    cmd_src = rnd[5:4];
    rnd     = lfsr(rnd);
    seen    = '0;
    req(op);
    wait_lvl(op, 1'b1, 5, n);
    wait_lvl(op, 1'b0, 300, n);
    check_bit("contact reached", 1'b1, op ? open_st : close_st);
    repeat (8) tick;
    check_bit("command on event", 1'b1, seen[op ? 10 : 14]);
    scan_log(op, (travel + 6) / MSC, cmd_src, sgil_pkg::SGIL_FAIL_NONE);
    check_bit("logged time and source", 1'b1, t_ok);
  endtask : operate

  // Block one source in one direction, raised early enough to count
  task automatic blk_try(input bit op, input int b);
    sgil_pkg::sgil_blk_src_t m;
    int                      hi;
    m = sgil_pkg::sgil_blk_src_t'(9'h001 << b);
    if (op)
    begin
      open_blk_en  = m;
      open_blk_src = m;
    end
    else
    begin
      close_blk_en  = m;
      close_blk_src = m;
    end
    repeat (5 * MSC + 6) tick;
    seen = '0;
    hi   = 0;
    req(op);
    repeat (12)
    begin
      hi += int'((op ? open_cmd : close_cmd) === 1'b1);
      tick;
    end
    check_val("blocked command", 32'h0, hi);
    check_bit("blocked event", 1'b1, seen[op ? 16 : 18]);
    open_blk_src  = '0;
    close_blk_src = '0;
    open_blk_en   = '0;
    close_blk_en  = '0;
    repeat (6) tick;
  endtask : blk_try

  initial
  begin
    {rst, open_req, close_req, stuck, welded, cmd_src, log_rd_idx, aux, seen, last_stamp} = '0;
    {open_blk_src, close_blk_src, open_blk_en, close_blk_en} = '0;
    rst = 1'b1;
    travel = 8'h0a;
    ev_on_en = '1;
    ev_off_en = '1;
    rnd = 32'hfe5b;
    error_cnt = 0;
    samples_checked = 0;
    repeat (2) tick;
    rst = 1'b0;
    check_val("log count after reset", 32'h0, log_count);
    repeat (8) tick;
    operate(1'b0, 1'b0);
    for (int b = 0; b < 9; b++)
      blk_try(1'b1, b);
    scan_log(1'b1, -10, 2'b00, sgil_pkg::SGIL_FAIL_BLOCKED);
    check_bit("open fail cause", 1'b1, f_ok);
    operate(1'b1, 1'b1);
    check_bit("intermediate event", 1'b1, seen[0]);
    check_bit("open event", 1'b1, seen[1]);
    for (int b = 0; b < 9; b++)
      blk_try(1'b0, b);
    scan_log(1'b0, -10, 2'b00, sgil_pkg::SGIL_FAIL_BLOCKED);
    check_bit("close fail cause", 1'b1, f_ok);
    // Open side blocked and close source active but disabled: close still runs
    open_blk_en   = '1;
    open_blk_src  = '1;
    close_blk_src = '1;
    repeat (5 * MSC + 6) tick;
    operate(1'b0, 1'b0);
    {open_blk_en, open_blk_src, close_blk_src} = '0;
    stuck = 1'b1;
    seen  = '0;
    req(1'b1);
    wait_lvl(1'b1, 1'b1, 5, n);
    wait_lvl(1'b1, 1'b0, 300, n);
    check_bit("timeout length", 1'b1, n >= TOUT - 3 && n <= TOUT + 3);
    repeat (4) tick;
    check_bit("open fail event", 1'b1, seen[24]);
    scan_log(1'b1, -10, 2'b00, sgil_pkg::SGIL_FAIL_TIMEOUT);
    check_bit("timeout cause", 1'b1, f_ok);
    stuck  = 1'b0;
    welded = 1'b1;
    seen   = '0;
    repeat (TRAV + 20) tick;
    check_bit("bad event", 1'b1, seen[3]);
    welded = 1'b0;
    repeat (TRAV + 20) tick;
    for (int i = 0; i < 18; i++)
    begin
      seen = '0;
      aux  = pat[i];
      repeat (TRAV + 20) tick;
      check_bit("edge event", 1'b1, seen[eid[i]]);
      check_val("snapshot", 32'(status_pin), 32'(last_proc));
    end
    check_val("log count full", 32'hc, log_count);
    scan_log(1'b1, -10, 2'b00, sgil_pkg::SGIL_FAIL_NONE);
    log_rd_idx = 4'h0;
    tick;
    check_val("newest entry", 32'd27, log_rd_data.event_id);
    log_rd_idx = 4'h1;
    tick;
    check_val("older entry", 32'd26, log_rd_data.event_id);
    log_rd_idx = 4'hc;
    tick;
    check_bit("beyond ring", 1'b1, log_rd_data === '0);
    // Off edge filtered, then on edge filtered
    for (int k = 0; k < 2; k++)
    begin
      ev_off_en[29] = k[0];
      ev_on_en[28]  = !k[0];
      seen = '0;
      aux  = 9'h010;
      repeat (TRAV) tick;
      aux  = 9'h000;
      repeat (TRAV) tick;
      check_bit("on edge selection", !k[0], seen[28]);
      check_bit("off edge selection", k[0], seen[29]);
    end
    wrap_up;
  end
endmodule : sgil_object_bench
`default_nettype wire
